// ==== tlb_debug_map.svh ====
//------------------------------------------------------------------
// tlb debug read-out: register offsets, field positions, resets
//------------------------------------------------------------------
// holds definitions only; included by the pointer, read-out, checker and test files, not by the package or the array model.
// assumes a 12-bit window of the global space 0 programming region.
`ifndef TLB_DEBUG_MAP_SVH
`define TLB_DEBUG_MAP_SVH

//------------------------------------------------------------------
// register offsets within the global space
//------------------------------------------------------------------
`define BUF_PTR_OFFSET 12'h080
`define BUF_DATA_OFFSET 12'h084
`define CTL_PTR_OFFSET 12'h088
`define CTL_DATA_OFFSET 12'h08c

//------------------------------------------------------------------
// pointer fields
//------------------------------------------------------------------
`define UNIT_SELECT_MSB 31
`define UNIT_SELECT_LSB 24
`define SOURCE_SELECT_MSB 27
`define SOURCE_SELECT_LSB 26
`define WAY_SELECT_MSB 25
`define WAY_SELECT_LSB 24
`define ENTRY_INDEX_MSB 15
`define ENTRY_INDEX_LSB 4
`define ENTRY_WORD_MSB 3
`define ENTRY_WORD_LSB 0
`define POINTER_RESET 32'h0000_0000
`define POINTER_STEP 32'h0000_0004

//------------------------------------------------------------------
// bus responses
//------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// ==== tlb_debug_pkg.sv ====
//------------------------------------------------------------------
// tlb debug read-out: shared types
//------------------------------------------------------------------
// holds the sequencer state type and the read source type.
// assumes nothing beyond the map header for constants.
package tlb_debug_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_wr_data,
        st_wr_resp,
        st_rd_decide,
        st_rd_fetch,
        st_rd_beat
    } seq_state_type;

    typedef enum logic [1:0] {
        src_main_tlb,
        src_prefetch,
        src_ipa_cache,
        src_walk_cache
    } read_source_type;

endpackage

// ==== tlb_read_pointer.sv ====
//------------------------------------------------------------------
// tlb debug read pointer register with auto advance
//------------------------------------------------------------------
// one instance per pointer register; the parent owns the bus decode.
// assumes write and advance never arrive in the same cycle.
`timescale 1ns/1ns
`include "tlb_debug_map.svh"

module tlb_read_pointer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic write_en,
    input wire logic [31:0] write_data,
    input wire logic [3:0] write_strobe,
    input wire logic advance,
    output logic [31:0] pointer
);

    logic [31:0] merged;
    logic [31:0] stepped;

    // byte lanes merge; low two bits forced to zero keep word alignment
    always_comb begin
        merged = pointer;
        for (int i = 0; i < 4; i++) begin
            if (write_strobe[i]) begin
                merged[i*8 +: 8] = write_data[i*8 +: 8];
            end
        end
        merged[1:0] = 2'h0;
    end

    assign stepped = pointer + `POINTER_STEP;

    // write first so a fresh pointer is never overrun by a stale step
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pointer <= `POINTER_RESET;
        end else if (write_en) begin
            pointer <= merged;
        end else if (advance) begin
            pointer <= stepped;
        end
    end

endmodule

// ==== tlb_debug_readout.sv ====
//------------------------------------------------------------------
// tlb debug read-out: axi4 programming slave for the debug registers
//------------------------------------------------------------------
// serves the buffer-unit and control-unit pointer/data pairs.
// assumes the tlb arrays sit outside and answer fetch_valid with
// one fetch_done pulse some cycles later, holding fetch_data then.
`timescale 1ns/1ns
`include "tlb_debug_map.svh"

module tlb_debug_readout
    import tlb_debug_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    // write address channel
    input wire logic [3:0] awid,
    input wire logic [11:0] awaddr,
    input wire logic [7:0] awlen,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wlast,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [3:0] bid,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [3:0] arid,
    input wire logic [11:0] araddr,
    input wire logic [7:0] arlen,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [3:0] rid,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rlast,
    output logic rvalid,
    input wire logic rready,
    // configured extents of the tlb arrays
    input wire logic [8:0] buffer_unit_count,
    input wire logic [12:0] buffer_entry_count,
    input wire logic [12:0] control_entry_count,
    // fetch port toward the tlb arrays
    output logic fetch_valid,
    output logic fetch_control_unit,
    output logic [31:0] fetch_pointer,
    input wire logic fetch_done,
    input wire logic [31:0] fetch_data
);

    //--------------------------------------------------------------
    // transaction state
    //--------------------------------------------------------------
    seq_state_type state;
    logic [3:0] cur_id;
    logic [11:0] cur_addr;
    logic [7:0] beats_left;
    logic cur_secure;
    logic [1:0] wr_resp_acc;

    logic [31:0] buffer_pointer;
    logic [31:0] control_pointer;

    //--------------------------------------------------------------
    // address decode
    //--------------------------------------------------------------
    wire [11:0] word_addr = {cur_addr[11:2], 2'h0};
    wire hit_buf_ptr = word_addr == `BUF_PTR_OFFSET;
    wire hit_buf_data = word_addr == `BUF_DATA_OFFSET;
    wire hit_ctl_ptr = word_addr == `CTL_PTR_OFFSET;
    wire hit_ctl_data = word_addr == `CTL_DATA_OFFSET;
    wire hit_ptr = hit_buf_ptr | hit_ctl_ptr;
    wire hit_data = hit_buf_data | hit_ctl_data;
    wire hit_any = hit_ptr | hit_data;

    // prot bit 1 low marks a secure transaction
    wire aw_secure = ~awprot[1];
    wire ar_secure = ~arprot[1];

    // error answer for this transaction, fixed once decoded
    wire [1:0] access_resp = !hit_any ? `RESP_DECERR :
                             !cur_secure ? `RESP_SLVERR : `RESP_OKAY;

    //--------------------------------------------------------------
    // extent checks on the pointer of the selected data register
    //--------------------------------------------------------------
    wire [7:0] buf_unit =
        buffer_pointer[`UNIT_SELECT_MSB:`UNIT_SELECT_LSB];
    wire [11:0] buf_entry =
        buffer_pointer[`ENTRY_INDEX_MSB:`ENTRY_INDEX_LSB];
    wire [11:0] ctl_entry =
        control_pointer[`ENTRY_INDEX_MSB:`ENTRY_INDEX_LSB];
    wire buf_in_range = ({1'b0, buf_unit} < buffer_unit_count) &&
                        ({1'b0, buf_entry} < buffer_entry_count);
    wire ctl_in_range = {1'b0, ctl_entry} < control_entry_count;
    wire data_in_range = hit_buf_data ? buf_in_range : ctl_in_range;

    // the source and way fields pass to the arrays inside the pointer
    wire [1:0] ctl_source_bits =
        control_pointer[`SOURCE_SELECT_MSB:`SOURCE_SELECT_LSB];
    read_source_type ctl_source;
    assign ctl_source = read_source_type'(ctl_source_bits);

    //--------------------------------------------------------------
    // control decisions
    //--------------------------------------------------------------
    wire take_aw = (state == st_idle) && awvalid;
    wire take_ar = (state == st_idle) && arvalid && !awvalid;
    wire w_beat = (state == st_wr_data) && wvalid && wready;
    wire ptr_write = w_beat && cur_secure;
    wire decide_fetch = (state == st_rd_decide) && cur_secure &&
                        hit_data && data_in_range;
    wire fetch_hit = (state == st_rd_fetch) && fetch_done;
    // out-of-range reads still step the pointer so a walk can cross
    wire decide_skip = (state == st_rd_decide) && cur_secure &&
                       hit_data && !data_in_range;
    wire step_data = fetch_hit | decide_skip;
    wire r_beat_done = (state == st_rd_beat) && rvalid && rready;
    wire last_beat = beats_left == 8'h00;

    //--------------------------------------------------------------
    // the two pointer registers
    //--------------------------------------------------------------
    // writes land only in st_wr_data and steps only on the read path,
    // so a finished pointer write is always seen by the next read
    tlb_read_pointer buf_ptr_reg (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .write_en(ptr_write && hit_buf_ptr),
        .write_data(wdata),
        .write_strobe(wstrb),
        .advance(step_data && hit_buf_data),
        .pointer(buffer_pointer)
    );

    tlb_read_pointer ctl_ptr_reg (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .write_en(ptr_write && hit_ctl_ptr),
        .write_data(wdata),
        .write_strobe(wstrb),
        .advance(step_data && hit_ctl_data),
        .pointer(control_pointer)
    );

    //--------------------------------------------------------------
    // read data selection for pointer and skipped reads
    //--------------------------------------------------------------
    wire [31:0] ptr_read_value = hit_buf_ptr ? buffer_pointer :
                                 control_pointer;
    wire [31:0] decide_value = (cur_secure && hit_ptr) ?
                               ptr_read_value : 32'h0000_0000;

    //--------------------------------------------------------------
    // sequencer: one transaction at a time, writes win a tie
    //--------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= st_idle;
        end else begin
            case (state)
                st_idle: begin
                    if (take_aw) begin
                        state <= st_wr_data;
                    end else if (take_ar) begin
                        state <= st_rd_decide;
                    end
                end
                st_wr_data: begin
                    if (w_beat && wlast) begin
                        state <= st_wr_resp;
                    end
                end
                st_wr_resp: begin
                    if (bready) begin
                        state <= st_idle;
                    end
                end
                st_rd_decide: begin
                    state <= decide_fetch ? st_rd_fetch : st_rd_beat;
                end
                st_rd_fetch: begin
                    if (fetch_done) begin
                        state <= st_rd_beat;
                    end
                end
                st_rd_beat: begin
                    if (rready) begin
                        state <= last_beat ? st_idle : st_rd_decide;
                    end
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // captured request attributes; a burst repeats its first address
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_id <= 4'h0;
            cur_addr <= 12'h000;
            beats_left <= 8'h00;
            cur_secure <= 1'b0;
        end else if (take_aw) begin
            cur_id <= awid;
            cur_addr <= awaddr;
            cur_secure <= aw_secure;
        end else if (take_ar) begin
            cur_id <= arid;
            cur_addr <= araddr;
            beats_left <= arlen;
            cur_secure <= ar_secure;
        end else if (r_beat_done && !last_beat) begin
            beats_left <= beats_left - 8'h01;
        end
    end

    // write channel handshakes; burst answer keeps the worst response
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bid <= 4'h0;
            bresp <= `RESP_OKAY;
            wr_resp_acc <= `RESP_OKAY;
        end else begin
            awready <= (state == st_idle) && awvalid && !awready;
            if (take_aw) begin
                wready <= 1'b1;
                wr_resp_acc <= `RESP_OKAY;
            end else if (w_beat && wlast) begin
                wready <= 1'b0;
            end
            if (w_beat && access_resp > wr_resp_acc) begin
                wr_resp_acc <= access_resp;
            end
            if (w_beat && wlast) begin
                bvalid <= 1'b1;
                bid <= cur_id;
                bresp <= (access_resp > wr_resp_acc) ?
                         access_resp : wr_resp_acc;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: fetched word or register value goes back as rdata
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rid <= 4'h0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
            rlast <= 1'b0;
        end else begin
            arready <= (state == st_idle) && arvalid && !awvalid &&
                       !arready;
            if ((state == st_rd_decide) && !decide_fetch) begin
                rvalid <= 1'b1;
                rdata <= decide_value;
                rresp <= access_resp;
                rid <= cur_id;
                rlast <= last_beat;
            end else if (fetch_hit) begin
                rvalid <= 1'b1;
                rdata <= fetch_data;
                rresp <= `RESP_OKAY;
                rid <= cur_id;
                rlast <= last_beat;
            end else if (r_beat_done) begin
                rvalid <= 1'b0;
                rlast <= 1'b0;
            end
        end
    end

    // fetch request toward the arrays: one pulse, pointer held with it
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_valid <= 1'b0;
            fetch_control_unit <= 1'b0;
            fetch_pointer <= `POINTER_RESET;
        end else begin
            fetch_valid <= decide_fetch;
            if (decide_fetch) begin
                fetch_control_unit <= hit_ctl_data;
                // tag and address words alike are reached by word index
                fetch_pointer <= hit_buf_data ? buffer_pointer :
                                 {control_pointer[31:28],
                                  ctl_source,
                                  control_pointer[25:0]};
            end
        end
    end

endmodule

// ==== tlb_debug_readout_properties.sv ====
// checker: bus answers and fetch port timing of the debug read-out
// assumes it is bound onto tlb_debug_readout and sees only its ports
`timescale 1ns/1ns
`include "tlb_debug_map.svh"

module tlb_debug_readout_properties (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [11:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic wlast,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic fetch_valid,
    input wire logic fetch_control_unit,
    input wire logic [31:0] fetch_pointer,
    input wire logic fetch_done,
    input wire logic [31:0] fetch_data
);
    //------------------------------------------------------------
    // helpers: the master holds araddr/arprot up to the arready edge
    //------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire sec_ar = arready && !arprot[1];
    wire is_ptr = araddr == `BUF_PTR_OFFSET || araddr == `CTL_PTR_OFFSET;
    wire is_dat = araddr == `BUF_DATA_OFFSET || araddr == `CTL_DATA_OFFSET;

    property p_nonsecure;
        arready && arprot[1] && (is_ptr || is_dat) |=> rvalid
            && rresp == `RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_nonsecure: assert property (p_nonsecure) else $error("open read");
    property p_unmapped;
        arready && !is_ptr && !is_dat |=> rvalid && rdata == 32'h0
            && rresp == `RESP_DECERR;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad decode");
    property p_ptr_low;
        sec_ar && is_ptr |=> rvalid && rdata[1:0] == 2'h0
            && rresp == `RESP_OKAY;
    endproperty
    a_ptr_low: assert property (p_ptr_low) else $error("ptr low bits");
    property p_buf_data;
        sec_ar && araddr == `BUF_DATA_OFFSET |=> fetch_valid
            && !fetch_control_unit || rvalid && rdata == 32'h0;
    endproperty
    a_buf_data: assert property (p_buf_data) else $error("buf fetch");
    property p_ctl_data;
        sec_ar && araddr == `CTL_DATA_OFFSET |=> fetch_valid
            && fetch_control_unit || rvalid && rdata == 32'h0;
    endproperty
    a_ctl_data: assert property (p_ctl_data) else $error("ctl fetch");
    property p_fetch_word;
        fetch_valid |-> fetch_pointer[1:0] == 2'h0 && !rvalid;
    endproperty
    a_fetch_word: assert property (p_fetch_word) else $error("fetch addr");
    property p_return;
        fetch_done |=> rvalid && rdata == $past(fetch_data)
            && rresp == `RESP_OKAY;
    endproperty
    a_return: assert property (p_return) else $error("fetch lost");
    property p_hold;
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_hold: assert property (p_hold) else $error("beat dropped");
    property p_write_resp;
        wvalid && wready && wlast |=> bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no bresp");
    c_stall: cover property (fetch_done ##1 rvalid && !rready);
    c_ctl: cover property (fetch_valid && fetch_control_unit);
    c_open: cover property (arready && arprot[1]);
endmodule

bind tlb_debug_readout tlb_debug_readout_properties u_props (
    .core_clk(core_clk), .arst_n(arst_n), .araddr(araddr),
    .arprot(arprot), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .wlast(wlast), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .fetch_valid(fetch_valid),
    .fetch_control_unit(fetch_control_unit),
    .fetch_pointer(fetch_pointer), .fetch_done(fetch_done),
    .fetch_data(fetch_data)
);

// ==== tlb_array_model.sv ====
// model of the tlb arrays behind the fetch port
// assumes one fetch at a time; slow stretches the answer to five cycles
`timescale 1ns/1ns

module tlb_array_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic slow,
    input wire logic fetch_valid,
    input wire logic fetch_control_unit,
    input wire logic [31:0] fetch_pointer,
    output logic fetch_done,
    output logic [31:0] fetch_data
);
    logic [2:0] wait_count;
    logic [31:0] held_word;
    // every pointer field shapes the word, so a wrong pick shows up
    wire [31:0] next_word = {fetch_control_unit, fetch_pointer[30:0]}
        ^ 32'h5a5a_0000;
    // data is only good with done; otherwise the inverse is shown
    assign fetch_data = fetch_done ? held_word : ~held_word;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_count <= 3'h0;
            fetch_done <= 1'b0;
            held_word <= 32'h0;
        end else begin
            fetch_done <= wait_count == 3'h1;
            if (fetch_valid) begin
                wait_count <= slow ? 3'h5 : 3'h1;
                held_word <= next_word;
            end else if (wait_count != 3'h0) begin
                wait_count <= wait_count - 3'h1;
            end
        end
    end
endmodule

// ==== tlb_debug_readout_test.sv ====
// testbench: axi4 master on the debug registers, arrays modelled apart
// assumes the read-out answers one transaction at a time
`timescale 1ns/1ns
`include "tlb_debug_map.svh"

module tlb_debug_readout_test;
    logic core_clk, arst_n, slow, awvalid, wvalid, wlast, bready, arvalid;
    logic rready, awready, wready, bvalid, arready, rvalid, rlast;
    logic fetch_valid, fetch_control_unit, fetch_done, cu;
    logic [3:0] awid, arid, wstrb, bid, rid;
    logic [11:0] awaddr, araddr;
    logic [7:0] awlen, arlen, len;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, fetch_pointer, fetch_data, ptr, seed;
    logic [1:0] bresp, rresp, resp;
    logic [8:0] buf_units;
    logic [12:0] buf_entries, ctl_entries;
    logic [31:0] rd_data [0:7];
    logic [1:0] rd_resp [0:7];
    int fail_count, n_tests, it, b;

    tlb_debug_readout u_dut (.core_clk(core_clk), .arst_n(arst_n),
        .awid(awid), .awaddr(awaddr), .awlen(awlen), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wlast(wlast), .wvalid(wvalid), .wready(wready), .bid(bid),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .arid(arid),
        .araddr(araddr), .arlen(arlen), .arprot(arprot), .arvalid(arvalid),
        .arready(arready), .rid(rid), .rdata(rdata), .rresp(rresp),
        .rlast(rlast), .rvalid(rvalid), .rready(rready),
        .buffer_unit_count(buf_units), .buffer_entry_count(buf_entries),
        .control_entry_count(ctl_entries), .fetch_valid(fetch_valid),
        .fetch_control_unit(fetch_control_unit),
        .fetch_pointer(fetch_pointer), .fetch_done(fetch_done),
        .fetch_data(fetch_data));
    tlb_array_model u_arrays (.core_clk(core_clk), .arst_n(arst_n),
        .slow(slow), .fetch_valid(fetch_valid),
        .fetch_control_unit(fetch_control_unit),
        .fetch_pointer(fetch_pointer), .fetch_done(fetch_done),
        .fetch_data(fetch_data));

    always #5 core_clk = ~core_clk;

    //------------------------------------------------------------
    // expectations, comparisons and the closing report
    //------------------------------------------------------------
    function automatic logic [31:0] exp_word(input logic c,
                                             input logic [31:0] p);
        return {c, p[30:0]} ^ 32'h5a5a_0000;
    endfunction
    function automatic logic in_range(input logic c, input logic [31:0] p);
        if (c) return p[15:4] < ctl_entries;
        return p[31:24] < buf_units && p[15:4] < buf_entries;
    endfunction
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t resp %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hang;
        fail_count++;
        $display("[FAIL] %0t no handshake", $time);
        final_report();
    endtask

    //------------------------------------------------------------
    // bus master: drive at negedge, hold until ready is sampled
    //------------------------------------------------------------
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                             input logic [2:0] p);
        logic aw_hs, w_hs;
        int n;
        @(negedge core_clk);
        awaddr = a;
        awprot = p;
        wdata = d;
        awid = 4'($urandom);
        awvalid = 1'b1;
        wvalid = 1'b1;
        aw_hs = 1'b0;
        w_hs = 1'b0;
        for (n = 0; n < 40; n++) begin
            @(negedge core_clk);
            if (aw_hs) awvalid = 1'b0;
            if (w_hs) wvalid = 1'b0;
            if (bvalid) break;
            aw_hs = awready && awvalid;
            w_hs = wready && wvalid;
        end
        if (n == 40) hang();
        resp = bresp;
        chk_data(bid, awid);
    endtask
    task automatic axi_read(input logic [11:0] a, input logic [2:0] p,
                            input logic [7:0] l);
        logic ar_hs;
        int n, beats;
        @(negedge core_clk);
        araddr = a;
        arprot = p;
        arlen = l;
        arid = 4'($urandom);
        arvalid = 1'b1;
        ar_hs = 1'b0;
        beats = 0;
        for (n = 0; n < 300 && beats <= l; n++) begin
            @(negedge core_clk);
            if (ar_hs) arvalid = 1'b0;
            ar_hs = arready && arvalid;
            rready = $urandom_range(0, 1);
            if (rvalid && rready) begin
                rd_data[beats] = rdata;
                chk_data({rid, rlast}, {arid, beats == l});
                rd_resp[beats] = rresp;
                beats++;
            end
        end
        if (beats <= l) hang();
    endtask

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        {core_clk, arst_n, slow, awvalid, wvalid, arvalid, rready} = '0;
        {awid, arid, awaddr, araddr, awlen, arlen, awprot, arprot} = '0;
        {wdata, fail_count, n_tests} = '0;
        {wstrb, wlast, bready} = 6'h3f;
        buf_units = 9'h002;
        buf_entries = 13'h0005;
        ctl_entries = 13'h0003;
        seed = $urandom(93352);
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        for (b = 0; b < 2; b++) begin
            axi_read(b ? `CTL_PTR_OFFSET : `BUF_PTR_OFFSET, 3'h0, 8'h0);
            chk_data(rd_data[0], 32'h0);
            axi_write(b ? `CTL_PTR_OFFSET : `BUF_PTR_OFFSET, '1, 3'h0);
            chk_resp(resp, `RESP_OKAY);
            axi_read(b ? `CTL_PTR_OFFSET : `BUF_PTR_OFFSET, 3'h0, 8'h0);
            chk_data(rd_data[0], 32'hffff_fffc);
        end
        axi_write(`BUF_PTR_OFFSET, 32'h1234_5678, 3'h2);
        chk_resp(resp, `RESP_SLVERR);
        axi_write(`BUF_DATA_OFFSET, 32'h0000_0010, 3'h0);
        chk_resp(resp, `RESP_OKAY);
        axi_read(`BUF_PTR_OFFSET, 3'h2, 8'h0);
        chk_resp(rd_resp[0], `RESP_SLVERR);
        chk_data(rd_data[0], 32'h0);
        axi_read(`BUF_PTR_OFFSET, 3'h0, 8'h0);
        chk_data(rd_data[0], 32'hffff_fffc);
        axi_read(12'h090, 3'h0, 8'h0);
        chk_resp(rd_resp[0], `RESP_DECERR);
        // a second reset in mid-run brings the pointers back to zero
        @(negedge core_clk) arst_n = 1'b0;
        @(negedge core_clk) arst_n = 1'b1;
        axi_read(`CTL_PTR_OFFSET, 3'h0, 8'h0);
        chk_data(rd_data[0], 32'h0);
        // the arrays see no other traffic while they are read out
        for (it = 0; it < 24; it++) begin
            cu = it[0];
            slow = $urandom_range(0, 1);
            ptr = $urandom;
            ptr[31:24] = cu ? {ptr[31:28], it[4:1]} : $urandom_range(0, 2);
            ptr[15:4] = $urandom_range(0, cu ? 3 : 5);
            ptr[3:0] = {$urandom_range(0, 3), 2'h0};
            len = $urandom_range(0, 3);
            if (it == 0) ptr = 32'h0000_004c;
            axi_write(cu ? `CTL_PTR_OFFSET : `BUF_PTR_OFFSET, ptr, 3'h0);
            chk_resp(resp, `RESP_OKAY);
            axi_read(cu ? `CTL_DATA_OFFSET : `BUF_DATA_OFFSET, 3'h0, len);
            for (b = 0; b <= len; b++) begin
                chk_data(rd_data[b], in_range(cu, ptr) ? exp_word(cu, ptr)
                    : 32'h0);
                ptr = ptr + 32'h4;
            end
            axi_read(cu ? `CTL_PTR_OFFSET : `BUF_PTR_OFFSET, 3'h0, 8'h0);
            chk_data(rd_data[0], ptr);
        end
        final_report();
    end
endmodule
